// ==== include/rate_status_map.vh ====
`ifndef RATE_STATUS_MAP_VH
`define RATE_STATUS_MAP_VH
// Clock rate of ref_clk_in in kHz (50 ns period)
`define CLK_KHZ 20000
// Longest lock time of an engaged recovery circuit, in microseconds
`define LOCK_TIME_US 500
// Cycles allowed for lock, rounded down: 500 us * 20 MHz
`define LOCK_CYCLES ((`LOCK_TIME_US * `CLK_KHZ) / 1000)
// Lock counter width
`define LOCK_CNT_W 14
// Last search count before lock; two short of the limit because the count starts at zero
// and the locked flag is registered once more at the block output
`define LOCK_LAST 14'h270E
// Equalization and emphasis setting widths and reset values
`define EQ_W 2
`define EQ_RESET 2'h0
`define EMPH_W 2
`define EMPH_RESET 2'h0
// Data path select codes
`define PATH_BYPASS 2'h0
`define PATH_RETIME 2'h1
`define PATH_LOOP 2'h2
// Recovery circuit state codes
`define CDR_OFF 2'h0
`define CDR_SEARCH 2'h1
`define CDR_LOCKED 2'h2
`endif

// ==== core/rate_status_ctrl.v ====
`timescale 1ns/1ps
`include "rate_status_map.vh"

////////////////////////////////////////////////////////////////////////////////
// One recovery circuit: search while engaged, lock on top-rate traffic only
module cdr_lock_ctrl
(
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire clk_en_in,
   input wire engage_in,
   input wire top_rate_traffic_in,
   output reg [1:0] state_out,
   output reg locked_out
);
   reg [`LOCK_CNT_W-1:0] cnt_r;
   reg [`LOCK_CNT_W-1:0] cnt_nxt;
   reg [1:0] state_nxt;

   // Next state; lower-rate traffic never drives lock because its coding differs
   always @*
   begin
      state_nxt = state_out;
      cnt_nxt = cnt_r;
      case (state_out)
         `CDR_OFF:
         begin
            cnt_nxt = {`LOCK_CNT_W{1'b0}};
            if (engage_in)
               state_nxt = `CDR_SEARCH;
         end
         `CDR_SEARCH:
         begin
            if (!engage_in)
               state_nxt = `CDR_OFF;
            else if (!top_rate_traffic_in)
               cnt_nxt = {`LOCK_CNT_W{1'b0}};
            else if (cnt_r == `LOCK_LAST)
               state_nxt = `CDR_LOCKED;
            else
               cnt_nxt = cnt_r + 1'b1;
         end
         `CDR_LOCKED:
         begin
            cnt_nxt = {`LOCK_CNT_W{1'b0}};
            if (!engage_in)
               state_nxt = `CDR_OFF;
            else if (!top_rate_traffic_in)
               state_nxt = `CDR_SEARCH;
         end
         default:
            state_nxt = `CDR_OFF;
      endcase
   end

   // Registered state; locked flag follows state one-for-one
   always @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         state_out <= `CDR_OFF;
         cnt_r <= {`LOCK_CNT_W{1'b0}};
         locked_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         state_out <= state_nxt;
         cnt_r <= cnt_nxt;
         locked_out <= (state_nxt == `CDR_LOCKED);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for one pin; the first stage feeds only the second
module pin_sync
#(
   parameter [0:0] RST_VAL = 1'b0
)
(
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire clk_en_in,
   input wire pin_in,
   output reg sync_out
);
   reg meta_r;

   // Reset value equals the pin's idle level, so no false edge follows reset
   always @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         meta_r <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else if (clk_en_in)
      begin
         meta_r <= pin_in;
         sync_out <= meta_r;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Receive speed select high switches the receive recovery circuit into the path.
// - An engaged recovery circuit locks within 500 us of top-rate traffic.
// - Recovery circuits never lock on the two lower rates.
// - Receive speed select low bypasses receive retiming.
// - Transmit speed select high switches the transmit recovery circuit into the path.
// - Transmit speed select low bypasses transmit retiming.
// - Select high means 14.025 Gb/s, low means 8.5 or 4.25 Gb/s.
// - Laser fault output is high during a transmitter fault, else low.
// - Transmitter is off while shut-off input is high or open.
// - Presence strap is driven to ground always.
// - Signal-lost output is high while the optical signal is lost.
// - Serial id uses one data line and one host-driven clock line.
// - Optical loopback retimes received optical data and sends it out optically.
// - Electrical loopback retimes incoming electrical data and returns it electrically.
// - Optional pass-through also sends looped data outbound.
// - Host picks a transmit input equalization setting during operation.
// - Host picks a receive output emphasis setting during operation.
// - Undriven speed selects read low, selecting lower rates and bypass.
module rate_status_ctrl
(
   input wire ref_clk_in,
   input wire rst_n_in,
   input wire clk_en_in,
   input wire receive_speed_select_in,
   input wire receive_speed_select_driven_in,
   input wire transmit_speed_select_in,
   input wire transmit_speed_select_driven_in,
   input wire tx_shutoff_in,
   input wire tx_shutoff_driven_in,
   input wire laser_fault_in,
   input wire optical_signal_ok_in,
   input wire rx_top_rate_traffic_in,
   input wire tx_top_rate_traffic_in,
   input wire optical_loopback_in,
   input wire electrical_loopback_in,
   input wire loop_pass_through_in,
   input wire [`EQ_W-1:0] tx_input_eq_in,
   input wire [`EMPH_W-1:0] rx_output_emph_in,
   input wire serial_id_clock_in,
   input wire serial_id_data_in,
   input wire serial_id_data_drive_in,
   output reg [1:0] rx_path_sel_out,
   output reg [1:0] tx_path_sel_out,
   output reg rx_cdr_locked_out,
   output reg tx_cdr_locked_out,
   output reg rx_rate_high_out,
   output reg tx_rate_high_out,
   output reg optical_tx_on_out,
   output reg loop_outbound_out,
   output reg laser_fault_out,
   output reg receive_signal_lost_out,
   output reg module_present_strap_out,
   output reg module_present_strap_oe_out,
   output reg [`EQ_W-1:0] tx_eq_sel_out,
   output reg [`EMPH_W-1:0] rx_emph_sel_out,
   output reg serial_id_clock_sync_out,
   output reg serial_id_data_sync_out,
   output reg serial_id_data_out,
   output reg serial_id_data_oe_out
);
   wire rx_pin;
   wire tx_pin;
   wire off_pin;
   wire rx_sel;
   wire tx_sel;
   wire shutoff;
   wire fault_s;
   wire signal_ok_s;
   wire id_clock_s;
   wire id_data_s;
   wire [1:0] rx_state;
   wire [1:0] tx_state;
   wire rx_lock;
   wire tx_lock;
   reg [1:0] rx_path_nxt;
   reg [1:0] tx_path_nxt;

   // Undriven selects read low, undriven shut-off reads high (internal pulls)
   assign rx_pin = receive_speed_select_in & receive_speed_select_driven_in;
   assign tx_pin = transmit_speed_select_in & transmit_speed_select_driven_in;
   assign off_pin = tx_shutoff_in | ~tx_shutoff_driven_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; selects are handled per direction, high means 14.025 Gb/s
   pin_sync #(.RST_VAL(1'b0)) u_rx_sel_sync
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .pin_in(rx_pin),
      .sync_out(rx_sel)
   );

   pin_sync #(.RST_VAL(1'b0)) u_tx_sel_sync
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .pin_in(tx_pin),
      .sync_out(tx_sel)
   );

   // Shut-off resets high so the laser stays dark until the pin is known
   pin_sync #(.RST_VAL(1'b1)) u_shutoff_sync
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .pin_in(off_pin),
      .sync_out(shutoff)
   );

   pin_sync #(.RST_VAL(1'b0)) u_fault_sync
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .pin_in(laser_fault_in),
      .sync_out(fault_s)
   );

   pin_sync #(.RST_VAL(1'b0)) u_signal_ok_sync
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .pin_in(optical_signal_ok_in),
      .sync_out(signal_ok_s)
   );

   // Id lines idle high on their pull-ups, so their stages reset high
   pin_sync #(.RST_VAL(1'b1)) u_id_clock_sync
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .pin_in(serial_id_clock_in),
      .sync_out(id_clock_s)
   );

   pin_sync #(.RST_VAL(1'b1)) u_id_data_sync
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .pin_in(serial_id_data_in),
      .sync_out(id_data_s)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Recovery circuits, engaged by select or by a loopback needing retiming
   cdr_lock_ctrl u_rx_cdr
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .engage_in(rx_sel | optical_loopback_in),
      .top_rate_traffic_in(rx_top_rate_traffic_in),
      .state_out(rx_state),
      .locked_out(rx_lock)
   );

   cdr_lock_ctrl u_tx_cdr
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .engage_in(tx_sel | electrical_loopback_in),
      .top_rate_traffic_in(tx_top_rate_traffic_in),
      .state_out(tx_state),
      .locked_out(tx_lock)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Path selection; loopback takes priority over normal retime or bypass
   always @*
   begin
      if (optical_loopback_in)
         rx_path_nxt = `PATH_LOOP;
      else if (rx_sel)
         rx_path_nxt = `PATH_RETIME;
      else
         rx_path_nxt = `PATH_BYPASS;
      if (electrical_loopback_in)
         tx_path_nxt = `PATH_LOOP;
      else if (tx_sel)
         tx_path_nxt = `PATH_RETIME;
      else
         tx_path_nxt = `PATH_BYPASS;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output registers; every output is a flip-flop
   always @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         rx_path_sel_out <= `PATH_BYPASS;
         tx_path_sel_out <= `PATH_BYPASS;
         rx_cdr_locked_out <= 1'b0;
         tx_cdr_locked_out <= 1'b0;
         rx_rate_high_out <= 1'b0;
         tx_rate_high_out <= 1'b0;
         optical_tx_on_out <= 1'b0;
         loop_outbound_out <= 1'b0;
         laser_fault_out <= 1'b0;
         receive_signal_lost_out <= 1'b1;
         module_present_strap_out <= 1'b0;
         module_present_strap_oe_out <= 1'b1;
         tx_eq_sel_out <= `EQ_RESET;
         rx_emph_sel_out <= `EMPH_RESET;
         serial_id_clock_sync_out <= 1'b1;
         serial_id_data_sync_out <= 1'b1;
         serial_id_data_out <= 1'b0;
         serial_id_data_oe_out <= 1'b0;
      end
      else if (clk_en_in)
      begin
         rx_path_sel_out <= rx_path_nxt;
         tx_path_sel_out <= tx_path_nxt;
         rx_cdr_locked_out <= rx_lock;
         tx_cdr_locked_out <= tx_lock;
         rx_rate_high_out <= rx_sel;
         tx_rate_high_out <= tx_sel;
         // Laser stays dark while shut off, even in loopback
         optical_tx_on_out <= ~shutoff;
         // Pass-through only means something while a loop is active
         loop_outbound_out <= loop_pass_through_in & (optical_loopback_in | electrical_loopback_in);
         laser_fault_out <= fault_s;
         receive_signal_lost_out <= ~signal_ok_s;
         // Strap always pulls the line to ground
         module_present_strap_out <= 1'b0;
         module_present_strap_oe_out <= 1'b1;
         // Settings retaken every cycle, so they can change in operation
         tx_eq_sel_out <= tx_input_eq_in;
         rx_emph_sel_out <= rx_output_emph_in;
         // Clock is host-driven; only the data line may be pulled low by us
         serial_id_clock_sync_out <= id_clock_s;
         serial_id_data_sync_out <= id_data_s;
         serial_id_data_out <= 1'b0;
         serial_id_data_oe_out <= serial_id_data_drive_in;
      end
   end
endmodule

// ==== sim/rate_status_ctrl_sva.sv ====
`timescale 1ns/1ps
`include "rate_status_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Ties status, path and lock outputs to the pin history
module rate_status_sva
(
   input logic ref_clk_in, rst_n_in, clk_en_in, laser_fault_in, optical_signal_ok_in,
   input logic receive_speed_select_in, receive_speed_select_driven_in,
   input logic transmit_speed_select_in, transmit_speed_select_driven_in,
   input logic tx_shutoff_in, tx_shutoff_driven_in, rx_top_rate_traffic_in,
   input logic optical_loopback_in, electrical_loopback_in,
   input logic [`EQ_W-1:0] tx_input_eq_in, tx_eq_sel_out,
   input logic [1:0] rx_path_sel_out, tx_path_sel_out,
   input logic rx_cdr_locked_out, optical_tx_on_out, laser_fault_out,
   input logic receive_signal_lost_out, module_present_strap_out, module_present_strap_oe_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [1:0] up_r;
   logic [13:0] run_r;
   wire rx_w = receive_speed_select_in & receive_speed_select_driven_in;
   wire tx_w = transmit_speed_select_in & transmit_speed_select_driven_in;
   wire off_w = tx_shutoff_in | ~tx_shutoff_driven_in;
   // Enabled edges since release or freeze, and enabled engaged traffic run
   always @(posedge ref_clk_in)
   begin
      up_r <= (!rst_n_in || !clk_en_in) ? 2'h0 : (up_r == 2'h3 ? up_r : up_r + 2'h1);
      run_r <= !clk_en_in ? run_r :
         (!(rx_top_rate_traffic_in && rx_path_sel_out != `PATH_BYPASS) ? 14'h0 : run_r + 14'h1);
   end
   a_fault_follows: assert property (up_r == 2'h3 |-> laser_fault_out == $past(laser_fault_in, 3))
      else $error("fault output does not follow fault pin");
   a_lost_follows: assert property (up_r == 2'h3 |-> receive_signal_lost_out != $past(optical_signal_ok_in, 3))
      else $error("signal lost output wrong");
   a_shutoff_dark: assert property (up_r == 2'h3 && $past(off_w, 3) |-> !optical_tx_on_out)
      else $error("laser on while shut off");
   a_strap_grounded: assert property (!module_present_strap_out && module_present_strap_oe_out)
      else $error("presence strap not driven low");
   a_rx_path_sel: assert property (up_r == 2'h3 |-> rx_path_sel_out ==
      ($past(optical_loopback_in) ? `PATH_LOOP : $past(rx_w, 3) ? `PATH_RETIME : `PATH_BYPASS))
      else $error("receive path select wrong");
   a_tx_path_sel: assert property (up_r == 2'h3 |-> tx_path_sel_out ==
      ($past(electrical_loopback_in) ? `PATH_LOOP : $past(tx_w, 3) ? `PATH_RETIME : `PATH_BYPASS))
      else $error("transmit path select wrong");
   a_lock_not_early: assert property ($rose(rx_cdr_locked_out) |-> run_r >= 14'h2706)
      else $error("receive lock came too early");
   a_lock_in_time: assert property (run_r >= 14'h2710 |-> rx_cdr_locked_out)
      else $error("receive lock came too late");
   a_lock_drops: assert property (!rx_top_rate_traffic_in && clk_en_in ##1 clk_en_in |-> ##1 !rx_cdr_locked_out)
      else $error("lock held without traffic");
   a_eq_follows: assert property (up_r == 2'h3 |-> tx_eq_sel_out == $past(tx_input_eq_in))
      else $error("equalization setting not taken");
   c_rx_locked: cover property ($rose(rx_cdr_locked_out));
   c_laser_off: cover property (optical_tx_on_out ##1 !optical_tx_on_out);
   c_rx_loop: cover property (rx_path_sel_out == `PATH_LOOP);
endmodule
bind rate_status_ctrl rate_status_sva u_sva (.*);

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host board: pull-up on the id data line, host-driven id clock, status synchronisers
module host_model
(
   input wire ref_clk_in,
   input wire id_clk_level_in,
   input wire sda_oe_in,
   input wire [2:0] status_in,
   output wire serial_id_clock_out,
   output wire serial_id_data_out,
   output reg [2:0] status_sync_out
);
   reg [2:0] meta_r;
   assign serial_id_clock_out = id_clk_level_in; // Only the host moves the id clock
   assign serial_id_data_out = ~sda_oe_in; // Pull-up wins unless the module sinks the line
   // Two stages so a changing status pin never reaches host logic half-settled
   always @(posedge ref_clk_in)
   begin
      meta_r <= status_in;
      status_sync_out <= meta_r;
   end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`include "rate_status_map.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
`define INS {receive_speed_select_in, receive_speed_select_driven_in, transmit_speed_select_in, \
   transmit_speed_select_driven_in, tx_shutoff_in, tx_shutoff_driven_in, laser_fault_in, optical_signal_ok_in, \
   rx_top_rate_traffic_in, tx_top_rate_traffic_in, optical_loopback_in, electrical_loopback_in, \
   loop_pass_through_in, serial_id_data_drive_in, id_clk_lvl, tx_input_eq_in, rx_output_emph_in}
////////////////////////////////////////////////////////////////////////////////
module testbench;
   reg ref_clk_in = 1'b0, rst_n_in = 1'b0, clk_en_in = 1'b1;
   reg receive_speed_select_in, receive_speed_select_driven_in, transmit_speed_select_in;
   reg transmit_speed_select_driven_in, tx_shutoff_in, tx_shutoff_driven_in, laser_fault_in;
   reg optical_signal_ok_in, rx_top_rate_traffic_in, tx_top_rate_traffic_in, optical_loopback_in;
   reg electrical_loopback_in, loop_pass_through_in, serial_id_data_drive_in, id_clk_lvl;
   reg [`EQ_W-1:0] tx_input_eq_in;
   reg [`EMPH_W-1:0] rx_output_emph_in;
   wire [1:0] rx_path_sel_out, tx_path_sel_out;
   wire [`EQ_W-1:0] tx_eq_sel_out;
   wire [`EMPH_W-1:0] rx_emph_sel_out;
   wire rx_cdr_locked_out, tx_cdr_locked_out, rx_rate_high_out, tx_rate_high_out, optical_tx_on_out;
   wire loop_outbound_out, laser_fault_out, receive_signal_lost_out, module_present_strap_out;
   wire module_present_strap_oe_out, serial_id_clock_sync_out, serial_id_data_sync_out;
   wire serial_id_data_out, serial_id_data_oe_out, serial_id_clock_in, serial_id_data_in;
   wire [2:0] host_sync;
   wire rx_s = receive_speed_select_in & receive_speed_select_driven_in;
   wire tx_s = transmit_speed_select_in & transmit_speed_select_driven_in;
   wire loop_any = optical_loopback_in | electrical_loopback_in;
   integer err_count = 0, checks = 0, i, n;
   reg [31:0] r;
   reg [8:0] snap;
   rate_status_ctrl u_dut (.*);
   host_model u_host (.ref_clk_in(ref_clk_in), .id_clk_level_in(id_clk_lvl), .sda_oe_in(serial_id_data_oe_out),
      .status_in({laser_fault_out, receive_signal_lost_out, module_present_strap_out}),
      .serial_id_clock_out(serial_id_clock_in), .serial_id_data_out(serial_id_data_in), .status_sync_out(host_sync));
   // 50 ns period
   always #25 ref_clk_in = ~ref_clk_in;
   ////////////////////////////////////////////////////////////////////////////////
   // Loop wins over select, select over bypass; an open select reads low
   function [1:0] path_f(input lp, input s);
      path_f = lp ? `PATH_LOOP : (s ? `PATH_RETIME : `PATH_BYPASS);
   endfunction
   // Drive all inputs in one step; top-rate traffic only while its select is high
   task apply_ins(input [18:0] v);
   begin
      `INS = {v[18:11], v[10] & v[18] & v[17], v[9] & v[16] & v[15], v[8:0]};
   end
   endtask
   task report_and_stop;
   begin
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   // Outputs once all pin inputs have crossed their synchronisers
   task check_all;
   begin
      `CHK("rx_path", path_f(optical_loopback_in, rx_s), rx_path_sel_out)
      `CHK("tx_path", path_f(electrical_loopback_in, tx_s), tx_path_sel_out)
      `CHK("rates", {rx_s, tx_s}, {rx_rate_high_out, tx_rate_high_out})
      `CHK("tx_on", ~tx_shutoff_in & tx_shutoff_driven_in, optical_tx_on_out)
      `CHK("fault", laser_fault_in, laser_fault_out)
      `CHK("lost", ~optical_signal_ok_in, receive_signal_lost_out)
      `CHK("outbound", loop_pass_through_in & loop_any, loop_outbound_out)
      `CHK("eq_emph", {tx_input_eq_in, rx_output_emph_in}, {tx_eq_sel_out, rx_emph_sel_out})
      `CHK("id_clock", id_clk_lvl, serial_id_clock_sync_out)
      `CHK("id_data", {~serial_id_data_drive_in, serial_id_data_drive_in}, {serial_id_data_sync_out, serial_id_data_oe_out})
      `CHK("host_view", {laser_fault_in, ~optical_signal_ok_in, 1'h0}, host_sync)
      `CHK("locks", 2'h0, {rx_cdr_locked_out, tx_cdr_locked_out})
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Random pin sweep, then a full lock and unlock on both directions
   initial
   begin
      `INS = 19'h0_0000;
      void'($urandom(57));
      repeat (12) @(negedge ref_clk_in);
      `CHK("reset", 5'h10, {receive_signal_lost_out, rx_path_sel_out, tx_path_sel_out})
      rst_n_in = 1'b1;
      for (i = 0; i < 60; i++)
      begin
         r = $urandom;
         apply_ins(r[18:0]); // Selects move independently, as in speed negotiation
         repeat (6) @(negedge ref_clk_in);
         check_all;
      end
      // Clock enable low freezes all state while every input except the masked top-rate traffic inverts
      snap = {rx_path_sel_out, tx_path_sel_out, laser_fault_out, receive_signal_lost_out, tx_eq_sel_out,
              optical_tx_on_out};
      clk_en_in = 1'b0;
      apply_ins(~r[18:0]);
      repeat (6) @(negedge ref_clk_in);
      `CHK("freeze", snap, {rx_path_sel_out, tx_path_sel_out, laser_fault_out, receive_signal_lost_out, tx_eq_sel_out, optical_tx_on_out})
      clk_en_in = 1'b1;
      repeat (6) @(negedge ref_clk_in);
      check_all;
      `INS = 19'h0_0000;
      {receive_speed_select_in, receive_speed_select_driven_in, transmit_speed_select_in} = 3'h7;
      {transmit_speed_select_driven_in, tx_shutoff_driven_in, optical_signal_ok_in} = 3'h7;
      repeat (5) @(negedge ref_clk_in);
      {rx_top_rate_traffic_in, tx_top_rate_traffic_in} = 2'h3;
      n = 0;
      while ({rx_cdr_locked_out, tx_cdr_locked_out} !== 2'h3 && n < 11000)
      begin
         @(negedge ref_clk_in);
         n++;
      end
      if (n >= 11000)
         err_count++;
      else
      begin
         `CHK("lock_time", 1'h1, (n >= 9990 && n <= 10000))
         {rx_top_rate_traffic_in, tx_top_rate_traffic_in} = 2'h0;
         repeat (3) @(negedge ref_clk_in);
         `CHK("unlock", 2'h0, {rx_cdr_locked_out, tx_cdr_locked_out})
      end
      report_and_stop;
   end
endmodule
